// *** rtl/panel_settings_store.sv ***
// How it works
// R01 - video system choice is kept in non-volatile storage until changed.
// R02 - no warning is raised for a video system mismatch.
// R03 - one video system bit governs incoming and outgoing video format.
// R04 - time code out runs while generating; muted on LTC idle if enabled.
// R05 - six general outputs: two logic level, four relays.
// R06 - relay 3 follows first aux level above -120 dB.
// R07 - relay 4 follows second aux level above -120 dB.
// R08 - host resends levels when channel order changes.
// R09 - one trim step moves the clock by 1/64 sample period.
// R10 - trim spans -999 to +999, stepped by Down and Up.
// R11 - Up held plus clock reference press on video item unlocks trim item.
// R12 - Set on a shown trim value stores it, back to time code.
// R13 - next Set shows trim item again; Down hides it until regesture.
// R14 - Up and Down held at power-up restore defaults, show banner.
// R15 - factory restore leaves the oscillator trim untouched.
// R16 - first group of factory default values.
// R17 - second group of factory default values.
// R18 - window burn factory defaults.
// R19 - parameters reload from storage at power-up unless restore gesture seen.
`timescale 1ns/1ns
module panel_settings_store (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_key_set,
    input wire logic i_key_up,
    input wire logic i_key_down,
    input wire logic i_key_clkref,
    input wire logic i_generating,
    input wire logic i_mtc_data,
    input wire logic i_ltc_idle,
    input wire panel_settings_pkg::settings_t i_nvm_settings,
    input wire logic signed [10:0] i_nvm_trim,
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output panel_settings_pkg::settings_t o_settings,
    output logic signed [10:0] o_osc_trim,
    output logic o_nvm_store,
    output panel_settings_pkg::settings_t o_nvm_settings,
    output logic signed [10:0] o_nvm_trim,
    output panel_settings_pkg::display_t o_display,
    output logic o_mtc_out,
    output logic [1:0] o_ttl_out,
    output logic [3:0] o_relay_out
);

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic signed [10:0] trim_step(input logic signed [10:0] v,
                                                     input logic up);
        logic signed [10:0] r;
        r = v;
        if (up) begin
            if (v < panel_settings_pkg::TRIM_MAX) begin
                r = v + panel_settings_pkg::TRIM_STEP;
            end
        end else begin
            if (v > panel_settings_pkg::TRIM_MIN) begin
                r = v - panel_settings_pkg::TRIM_STEP;
            end
        end
        return r;
    endfunction : trim_step

    function automatic logic level_above(input logic signed [15:0] level);
        return level > panel_settings_pkg::FADER_THRESHOLD_DB;
    endfunction : level_above

    ////////////////////////////////////////////////////////////////////////////
    panel_settings_pkg::keys_t keys_q;
    panel_settings_pkg::menu_t menu;
    panel_settings_pkg::item_t item;
    panel_settings_pkg::settings_t settings;
    logic signed [10:0] trim;
    logic signed [10:0] edit_value;
    logic trim_unlocked;
    logic restored;
    logic [31:0] aux_levels;
    logic [3:0] gpi_ctrl;
    logic bus_req;
    logic bus_accept;
    logic set_rise;
    logic up_fall;
    logic up_rise;
    logic down_rise;
    logic clkref_rise;
    logic signed [15:0] aux_first;
    logic signed [15:0] aux_second;

    assign bus_req = i_avs_read | i_avs_write;
    assign bus_accept = bus_req & ~o_avs_waitrequest;
    assign set_rise = i_key_set & ~keys_q.set;
    assign up_rise = i_key_up & ~keys_q.up;
    assign up_fall = ~i_key_up & keys_q.up;
    assign down_rise = i_key_down & ~keys_q.down;
    assign clkref_rise = i_key_clkref & ~keys_q.clkref;
    assign aux_first = aux_levels[panel_settings_pkg::AUX_FIRST_LSB +: 16];
    assign aux_second = aux_levels[panel_settings_pkg::AUX_SECOND_LSB +: 16];

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            keys_q <= '0;
        end else begin
            keys_q <= '{set: i_key_set, up: i_key_up, down: i_key_down,
                        clkref: i_key_clkref};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // front-panel menu with settings and trim
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            menu <= panel_settings_pkg::MENU_BOOT;
            item <= panel_settings_pkg::ITEM_VIDEO;
            settings <= panel_settings_pkg::FACTORY_SETTINGS; // see R16 see R17 see R18
            trim <= '0;
            edit_value <= '0;
            trim_unlocked <= 1'b0;
            restored <= 1'b0;
            o_nvm_store <= 1'b0;
        end else begin
            o_nvm_store <= 1'b0;
            case (menu)
                panel_settings_pkg::MENU_BOOT: begin
                    // keys sampled after reset release
                    trim <= i_nvm_trim; // see R15
                    if (i_key_up && i_key_down) begin
                        // user is expected to have held power off long enough
                        settings <= panel_settings_pkg::FACTORY_SETTINGS; // see R14
                        restored <= 1'b1;
                        o_nvm_store <= 1'b1;
                        menu <= panel_settings_pkg::MENU_BANNER;
                    end else begin
                        settings <= i_nvm_settings; // see R19 see R01
                        menu <= panel_settings_pkg::MENU_TIMECODE;
                    end
                end
                panel_settings_pkg::MENU_BANNER: begin
                    if (set_rise) begin
                        menu <= panel_settings_pkg::MENU_TIMECODE;
                    end
                end
                panel_settings_pkg::MENU_TIMECODE: begin
                    if (set_rise) begin
                        menu <= panel_settings_pkg::MENU_ITEM;
                        item <= trim_unlocked ? panel_settings_pkg::ITEM_TRIM
                                              : panel_settings_pkg::ITEM_VIDEO; // see R13
                    end
                end
                panel_settings_pkg::MENU_ITEM: begin
                    if (set_rise) begin
                        menu <= panel_settings_pkg::MENU_EDIT;
                        case (item)
                            panel_settings_pkg::ITEM_VIDEO:
                                edit_value <= $signed({10'h000, settings.video_pal});
                            panel_settings_pkg::ITEM_IDLE:
                                edit_value <= $signed({10'h000, settings.idle_mute});
                            default: edit_value <= trim;
                        endcase
                    end else if (item == panel_settings_pkg::ITEM_TRIM) begin
                        if (down_rise) begin
                            trim_unlocked <= 1'b0; // see R13
                            item <= panel_settings_pkg::ITEM_VIDEO;
                        end
                    end else if (item == panel_settings_pkg::ITEM_VIDEO && i_key_up
                                 && clkref_rise) begin
                        // up moves on release so the held key can open the gesture
                        trim_unlocked <= 1'b1; // see R11
                        item <= panel_settings_pkg::ITEM_TRIM;
                    end else if (down_rise || up_fall) begin
                        item <= (item == panel_settings_pkg::ITEM_VIDEO)
                              ? panel_settings_pkg::ITEM_IDLE
                              : panel_settings_pkg::ITEM_VIDEO;
                    end
                end
                panel_settings_pkg::MENU_EDIT: begin
                    if (set_rise) begin
                        o_nvm_store <= 1'b1;
                        case (item)
                            panel_settings_pkg::ITEM_VIDEO: begin
                                // no check against the applied video, by design
                                settings.video_pal <= edit_value[0]; // see R03 see R02
                                menu <= panel_settings_pkg::MENU_ITEM;
                            end
                            panel_settings_pkg::ITEM_IDLE: begin
                                settings.idle_mute <= edit_value[0];
                                menu <= panel_settings_pkg::MENU_ITEM;
                            end
                            default: begin
                                trim <= edit_value; // see R12
                                menu <= panel_settings_pkg::MENU_TIMECODE;
                            end
                        endcase
                    end else if (up_rise || down_rise) begin
                        if (item == panel_settings_pkg::ITEM_TRIM) begin
                            edit_value <= trim_step(edit_value, up_rise); // see R10
                        end else begin
                            edit_value <= $signed({10'h000, ~edit_value[0]});
                        end
                    end
                end
                default: begin
                    menu <= panel_settings_pkg::MENU_TIMECODE;
                end
            endcase
            // a bus write to the panel word lands after the menu, so it wins
            if (bus_accept && i_avs_write && i_avs_address == panel_settings_pkg::REG_PANEL
                && i_avs_byteenable[0]) begin
                settings.video_pal <= i_avs_writedata[panel_settings_pkg::PANEL_VIDEO_PAL_BIT];
                settings.idle_mute <= i_avs_writedata[panel_settings_pkg::PANEL_IDLE_MUTE_BIT];
                o_nvm_store <= 1'b1; // see R01
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // host-fed registers
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            aux_levels <= panel_settings_pkg::AUX_LEVELS_RESET;
            gpi_ctrl <= panel_settings_pkg::GPI_RESET;
        end else if (bus_accept && i_avs_write) begin
            if (i_avs_address == panel_settings_pkg::REG_AUX_LEVELS) begin
                // host rewrites both levels whenever its channel order changes
                for (int b = 0; b < 4; b++) begin
                    if (i_avs_byteenable[b]) begin
                        aux_levels[b*8 +: 8] <= i_avs_writedata[b*8 +: 8]; // see R08
                    end
                end
            end
            if (i_avs_address == panel_settings_pkg::REG_GPI && i_avs_byteenable[0]) begin
                gpi_ctrl <= i_avs_writedata[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // avalon slave, always one wait state
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= '0;
        end else begin
            o_avs_waitrequest <= ~(bus_req & o_avs_waitrequest);
            if (bus_req && o_avs_waitrequest) begin
                case (i_avs_address)
                    panel_settings_pkg::REG_STATUS:
                        o_avs_readdata <= {21'h000000, o_relay_out, restored,
                                           trim_unlocked, item, menu};
                    panel_settings_pkg::REG_PANEL:
                        o_avs_readdata <= {30'h00000000, settings.idle_mute,
                                           settings.video_pal};
                    panel_settings_pkg::REG_AUX_LEVELS:
                        o_avs_readdata <= aux_levels;
                    panel_settings_pkg::REG_GPI:
                        o_avs_readdata <= {28'h0000000, gpi_ctrl};
                    panel_settings_pkg::REG_OSC_TRIM:
                        o_avs_readdata <= {{21{trim[10]}}, trim};
                    default:
                        o_avs_readdata <= '0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all registered
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_mtc_out <= 1'b0;
            o_ttl_out <= '0;
            o_relay_out <= '0;
        end else begin
            o_mtc_out <= i_generating & i_mtc_data
                       & ~(settings.idle_mute & i_ltc_idle); // see R04
            o_ttl_out <= gpi_ctrl[panel_settings_pkg::GPI_TTL_LSB +: 2]; // see R05
            o_relay_out[1:0] <= gpi_ctrl[panel_settings_pkg::GPI_RELAY_LSB +: 2];
            o_relay_out[2] <= level_above(aux_first); // see R06
            o_relay_out[3] <= level_above(aux_second); // see R07
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_settings <= panel_settings_pkg::FACTORY_SETTINGS;
            o_osc_trim <= '0;
            o_nvm_settings <= panel_settings_pkg::FACTORY_SETTINGS;
            o_nvm_trim <= '0;
            o_display <= '0;
        end else begin
            o_settings <= settings;
            // units of 1/64 sample period
            o_osc_trim <= trim; // see R09
            o_nvm_settings <= settings;
            o_nvm_trim <= trim;
            o_display.menu <= menu;
            o_display.item <= item;
            o_display.value <= (menu == panel_settings_pkg::MENU_EDIT) ? edit_value : trim;
        end
    end

endmodule : panel_settings_store

// *** shared/panel_settings_pkg.sv ***
package panel_settings_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register map, byte addresses on a 32-bit avalon-mm slave
    localparam logic [4:0] REG_STATUS = 5'h00;
    localparam logic [4:0] REG_PANEL = 5'h04;
    localparam logic [4:0] REG_AUX_LEVELS = 5'h08;
    localparam logic [4:0] REG_GPI = 5'h0C;
    localparam logic [4:0] REG_OSC_TRIM = 5'h10;

    // field positions
    localparam int PANEL_VIDEO_PAL_BIT = 0;
    localparam int PANEL_IDLE_MUTE_BIT = 1;
    localparam int AUX_FIRST_LSB = 0;
    localparam int AUX_SECOND_LSB = 16;
    localparam int GPI_TTL_LSB = 0;
    localparam int GPI_RELAY_LSB = 2;

    // reset values of the bus registers
    localparam logic [31:0] AUX_LEVELS_RESET = 32'h8000_8000;
    localparam logic [3:0] GPI_RESET = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // fader start threshold, signed dB
    localparam logic signed [15:0] FADER_THRESHOLD_DB = 16'shFF88;

    // oscillator trim, steps of 1/64 sample period
    localparam logic signed [10:0] TRIM_MAX = 11'sh3E7;
    localparam logic signed [10:0] TRIM_MIN = 11'sh419;
    localparam logic signed [10:0] TRIM_STEP = 11'sh001;

    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        MENU_BOOT,
        MENU_TIMECODE,
        MENU_ITEM,
        MENU_EDIT,
        MENU_BANNER
    } menu_t;

    typedef enum logic [1:0] {
        ITEM_VIDEO,
        ITEM_IDLE,
        ITEM_TRIM
    } item_t;

    typedef struct packed {
        logic set;
        logic up;
        logic down;
        logic clkref;
    } keys_t;

    typedef struct packed {
        logic [31:0] gen_start_bcd;
        logic dig_ref_wordclock;
        logic [2:0] sample_rate_code;
        logic vitc_insert;
        logic [1:0] pull_rate_1;
        logic [1:0] pull_rate_4;
        logic base_clock_256x;
        logic [7:0] reader_line;
        logic [7:0] gen_line;
        logic burn_enable;
        logic [7:0] freewheel_frames;
        logic signed [5:0] ltc_gain_dbu;
        logic signed [3:0] servo_gain;
        logic pitch_hold;
        logic [15:0] biphase_ppf;
        logic biphase_b_leads;
        logic video_pal;
        logic idle_mute;
        logic burn_size_small;
        logic [1:0] burn_hpos;
        logic [6:0] burn_vpos_pct;
        logic burn_black_on_white;
        logic variable_speed_offset;
    } settings_t;

    // sample_rate_code 0 is 44.1 kHz, reader_line 0 searches all lines,
    // gen_line holds the first line of the pair, hpos 0 is centred
    localparam settings_t FACTORY_SETTINGS = '{
        gen_start_bcd: 32'h0000_0000,
        dig_ref_wordclock: 1'h0,
        sample_rate_code: 3'h0,
        vitc_insert: 1'h1,
        pull_rate_1: 2'h0,
        pull_rate_4: 2'h0,
        base_clock_256x: 1'h0,
        reader_line: 8'h00,
        gen_line: 8'h0E,
        burn_enable: 1'h1,
        freewheel_frames: 8'h08,
        ltc_gain_dbu: 6'sh03,
        servo_gain: 4'shF,
        pitch_hold: 1'h0,
        biphase_ppf: 16'h0064,
        biphase_b_leads: 1'h0,
        video_pal: 1'h0,
        idle_mute: 1'h1,
        burn_size_small: 1'h0,
        burn_hpos: 2'h0,
        burn_vpos_pct: 7'h14,
        burn_black_on_white: 1'h0,
        variable_speed_offset: 1'h0
    };

    typedef struct packed {
        menu_t menu;
        item_t item;
        logic signed [10:0] value;
    } display_t;

endpackage : panel_settings_pkg

// *** bench/panel_settings_store_properties.sv ***
`timescale 1ns/1ns
module panel_settings_store_properties (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_key_up,
    input wire logic i_key_down,
    input wire logic i_key_clkref,
    input wire logic i_generating,
    input wire logic i_mtc_data,
    input wire logic i_ltc_idle,
    input wire panel_settings_pkg::settings_t i_nvm_settings,
    input wire logic signed [10:0] i_nvm_trim,
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic o_avs_waitrequest,
    input wire panel_settings_pkg::settings_t o_settings,
    input wire logic signed [10:0] o_osc_trim,
    input wire logic o_nvm_store,
    input wire logic signed [10:0] o_nvm_trim,
    input wire panel_settings_pkg::display_t o_display,
    input wire logic o_mtc_out,
    input wire logic [3:0] o_relay_out
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);
    wire aux_wr = i_avs_write && !o_avs_waitrequest
        && i_avs_address == panel_settings_pkg::REG_AUX_LEVELS;
    wire on_item = o_display.menu == panel_settings_pkg::MENU_ITEM;
    wire on_trim = o_display.item == panel_settings_pkg::ITEM_TRIM;
    ////////////////////////////////////////////////////////////////////////////
    property p_mtc_off;
        !i_generating |=> !o_mtc_out;
    endproperty
    a_mtc_off: assert property (p_mtc_off) else $error("mtc not off");
    property p_mtc_on;
        i_generating && i_mtc_data && !i_ltc_idle |=> o_mtc_out;
    endproperty
    a_mtc_on: assert property (p_mtc_on) else $error("mtc out dropped");
    property p_mtc_mute;
        i_ltc_idle ##1 o_settings.idle_mute |-> !o_mtc_out;
    endproperty
    a_mtc_mute: assert property (p_mtc_mute) else $error("mtc not muted");
    property p_relay3;
        aux_wr |-> ##2 o_relay_out[2] == ($signed($past(i_avs_writedata[15:0], 2)) > -16'sd120);
    endproperty
    a_relay3: assert property (p_relay3) else $error("relay 3 wrong");
    property p_relay4;
        aux_wr |-> ##2 o_relay_out[3] == ($signed($past(i_avs_writedata[31:16], 2)) > -16'sd120);
    endproperty
    a_relay4: assert property (p_relay4) else $error("relay 4 wrong");
    property p_trim_range;
        o_osc_trim <= panel_settings_pkg::TRIM_MAX && o_osc_trim >= panel_settings_pkg::TRIM_MIN;
    endproperty
    a_trim_range: assert property (p_trim_range) else $error("trim out of range");
    property p_banner;
        o_display.menu == panel_settings_pkg::MENU_BANNER |->
            o_osc_trim == i_nvm_trim && o_settings == panel_settings_pkg::FACTORY_SETTINGS;
    endproperty
    a_banner: assert property (p_banner) else $error("restore state wrong");
    property p_load;
        o_display.menu == panel_settings_pkg::MENU_BOOT ##1
            o_display.menu == panel_settings_pkg::MENU_TIMECODE |-> o_settings == i_nvm_settings;
    endproperty
    a_load: assert property (p_load) else $error("load wrong");
    property p_store_data;
        o_nvm_store |=> o_nvm_trim == o_osc_trim;
    endproperty
    a_store_data: assert property (p_store_data) else $error("stored trim wrong");
    property p_unlock;
        on_item && o_display.item == panel_settings_pkg::ITEM_VIDEO && i_key_up
            && $rose(i_key_clkref) |-> ##[1:3] on_trim;
    endproperty
    a_unlock: assert property (p_unlock) else $error("trim item not shown");
    property p_hide;
        on_item && on_trim && $rose(i_key_down)
            |-> ##[1:3] o_display.item == panel_settings_pkg::ITEM_VIDEO;
    endproperty
    a_hide: assert property (p_hide) else $error("trim item not hidden");
    property p_wait_one;
        !o_avs_waitrequest |=> o_avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait low twice");
    c_banner: cover property (o_display.menu == panel_settings_pkg::MENU_BANNER);
    c_trim: cover property (on_trim);
    c_relay: cover property (o_relay_out[3:2] == 2'h3);
endmodule : panel_settings_store_properties

// *** bench/panel_front_model.sv ***
`timescale 1ns/1ns
module panel_front_model (
    input wire logic i_clock,
    output panel_settings_pkg::keys_t o_keys
);
    initial o_keys = '0;
    task set_key(input int k, input logic v);
        @(posedge i_clock);
        o_keys[k] <= v;
        @(posedge i_clock);
    endtask : set_key
    task tap(input int k);
        set_key(k, 1'b1);
        set_key(k, 1'b0);
    endtask : tap
endmodule : panel_front_model

// *** bench/panel_settings_store_tb.sv ***
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module panel_settings_store_tb;
    localparam int K_SET = 3, K_UP = 2, K_DOWN = 1, K_CLK = 0;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic i_generating = 1'b0;
    logic i_mtc_data = 1'b0;
    logic i_ltc_idle = 1'b0;
    logic [4:0] i_avs_address = 5'h00;
    logic i_avs_read = 1'b0;
    logic i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0000_0000;
    logic [31:0] o_avs_readdata, rd;
    logic o_avs_waitrequest, o_nvm_store, o_mtc_out;
    logic signed [10:0] o_osc_trim, o_nvm_trim;
    logic signed [10:0] i_nvm_trim = -11'sd998;
    logic [1:0] o_ttl_out;
    logic [3:0] o_relay_out;
    panel_settings_pkg::settings_t i_nvm_settings, o_settings, o_nvm_settings, s;
    panel_settings_pkg::display_t o_display;
    panel_settings_pkg::keys_t keys;
    int error_cnt = 0;
    int n_checks = 0;
    int cycles = 0;
    logic stored;
    panel_front_model u_front (.i_clock(i_clock), .o_keys(keys));
    panel_settings_store DUT (.*, .i_key_set(keys.set), .i_key_up(keys.up),
        .i_key_down(keys.down), .i_key_clkref(keys.clkref), .i_avs_byteenable(4'hF));
    initial forever #5 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        cycles++;
        if (o_nvm_store === 1'b1) stored = 1'b1;
        if (cycles == 30000) begin
            error_cnt++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task close_out();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    task look(input int n);
        repeat (n) @(negedge i_clock);
    endtask : look
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_avs_write <= w;
        i_avs_read <= !w;
        i_avs_address <= a;
        i_avs_writedata <= d;
        do @(posedge i_clock); while (o_avs_waitrequest !== 1'b0);
        rd = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
    endtask : bus
    task restart(input logic held);
        @(posedge i_clock);
        i_rst <= 1'b1;
        u_front.o_keys <= {1'b0, held, held, 1'b0};
        repeat (4) @(posedge i_clock);
        i_rst <= 1'b0;
        repeat (6) @(posedge i_clock);
        u_front.o_keys <= '0;
        look(2);
    endtask : restart
    ////////////////////////////////////////////////////////////////////////////
    task t_boot();
        restart(1'b0);
        `CHK(o_settings, i_nvm_settings)
        `CHK(o_settings.video_pal, 1'b1)
        `CHK(o_display.menu, panel_settings_pkg::MENU_TIMECODE)
        $display("t_boot done");
    endtask : t_boot
    task t_regs();
        bus(1'b0, panel_settings_pkg::REG_AUX_LEVELS, 32'h0);
        `CHK(rd, 32'h8000_8000)
        bus(1'b1, 5'h14, 32'hFFFF_FFFF);
        bus(1'b0, 5'h14, 32'h0);
        `CHK(rd, 32'h0000_0000)
        bus(1'b1, panel_settings_pkg::REG_GPI, 32'h0000_000F);
        look(2);
        `CHK({o_relay_out, o_ttl_out}, 6'h0F)
        bus(1'b1, panel_settings_pkg::REG_GPI, 32'h0000_0005);
        look(2);
        `CHK({o_relay_out, o_ttl_out}, 6'h05)
        $display("t_regs done");
    endtask : t_regs
    task t_fader();
        logic [31:0] lv [4] = '{32'hFF89_FF88, 32'hFF88_FF89, 32'hFF87_0000, 32'h0005_0000};
        logic [1:0] ex [4] = '{2'h2, 2'h1, 2'h1, 2'h3};
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, panel_settings_pkg::REG_AUX_LEVELS, lv[i]);
            look(2);
            `CHK(o_relay_out[3:2], ex[i])
        end
        $display("t_fader done");
    endtask : t_fader
    task t_mtc();
        bus(1'b1, panel_settings_pkg::REG_PANEL, 32'h3);
        i_generating <= 1'b1;
        i_mtc_data <= 1'b1;
        look(3);
        `CHK(o_mtc_out, 1'b1)
        @(posedge i_clock);
        i_ltc_idle <= 1'b1;
        look(3);
        `CHK(o_mtc_out, 1'b0)
        bus(1'b1, panel_settings_pkg::REG_PANEL, 32'h1);
        look(3);
        `CHK(o_mtc_out, 1'b1)
        @(posedge i_clock);
        i_generating <= 1'b0;
        look(3);
        `CHK(o_mtc_out, 1'b0)
        $display("t_mtc done");
    endtask : t_mtc
    task t_video();
        repeat (2) u_front.tap(K_SET);
        u_front.tap(K_UP);
        stored = 1'b0;
        u_front.tap(K_SET);
        look(2);
        `CHK(o_settings.video_pal, 1'b0)
        `CHK({stored, o_nvm_settings.video_pal}, 2'b10)
        `CHK(o_display.item, panel_settings_pkg::ITEM_VIDEO)
        $display("t_video done");
    endtask : t_video
    task t_trim();
        u_front.set_key(K_UP, 1'b1);
        u_front.tap(K_CLK);
        u_front.set_key(K_UP, 1'b0);
        look(1);
        `CHK(o_display.item, panel_settings_pkg::ITEM_TRIM)
        u_front.tap(K_SET);
        repeat (2) u_front.tap(K_DOWN);
        look(1);
        `CHK(o_display.value, -11'sd999)
        repeat (2) u_front.tap(K_UP);
        u_front.tap(K_SET);
        look(2);
        `CHK(o_display.menu, panel_settings_pkg::MENU_TIMECODE)
        `CHK({o_osc_trim, o_nvm_trim}, {-11'sd997, -11'sd997})
        u_front.tap(K_SET);
        look(1);
        `CHK(o_display.item, panel_settings_pkg::ITEM_TRIM)
        u_front.tap(K_DOWN);
        look(1);
        `CHK(o_display.item, panel_settings_pkg::ITEM_VIDEO)
        $display("t_trim done");
    endtask : t_trim
    task t_factory();
        restart(1'b1);
        s = o_settings;
        `CHK(o_display.menu, panel_settings_pkg::MENU_BANNER)
        `CHK(o_osc_trim, i_nvm_trim)
        `CHK({s.gen_start_bcd, s.sample_rate_code, s.reader_line, s.gen_line}, 51'h0E)
        `CHK({s.vitc_insert, s.dig_ref_wordclock, s.pull_rate_1, s.pull_rate_4}, 6'h20)
        `CHK({s.freewheel_frames, s.ltc_gain_dbu, s.servo_gain}, 18'h0203F)
        `CHK({s.biphase_ppf, s.biphase_b_leads, s.video_pal, s.idle_mute}, 19'h00321)
        `CHK({s.pitch_hold, s.variable_speed_offset, s.base_clock_256x}, 3'h0)
        `CHK({s.burn_enable, s.burn_size_small, s.burn_hpos, s.burn_vpos_pct}, 11'h414)
        `CHK(s.burn_black_on_white, 1'b0)
        u_front.tap(K_SET);
        look(1);
        `CHK(o_display.menu, panel_settings_pkg::MENU_TIMECODE)
        $display("t_factory done");
    endtask : t_factory
    initial begin
        i_nvm_settings = panel_settings_pkg::FACTORY_SETTINGS;
        i_nvm_settings.video_pal = 1'b1;
        i_nvm_settings.idle_mute = 1'b0;
        i_nvm_settings.freewheel_frames = 8'h19;
        stored = 1'b0;
        t_boot();
        t_regs();
        t_fader();
        t_mtc();
        t_video();
        t_trim();
        t_factory();
        close_out();
    end
endmodule : panel_settings_store_tb
bind panel_settings_store panel_settings_store_properties u_props (.*);
